/* inc/t16_pkg.sv */
package t16_pkg;

    // channel geometry
    localparam int N_CH    = 23;
    localparam int N_MR    = 24;
    localparam int CW      = 16;
    localparam int CYC_MR  = 23;
    localparam int CAPTURE_CHANNEL_ZERO_BIT = 24;
    localparam int FLAG_W  = 25;
    localparam int MODE_W  = 2;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_TC        = 8'h08;
    localparam logic [7:0] OFS_MR_FIRST  = 8'h20;
    localparam logic [7:0] OFS_MR_LAST   = 8'h7C;
    localparam logic [7:0] OFS_EXT_MATCH = 8'h80;
    localparam logic [7:0] OFS_OUT_MODE0 = 8'h84;
    localparam logic [7:0] OFS_OUT_MODE1 = 8'h88;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h94;
    localparam logic [7:0] OFS_PWM_MODE  = 8'h9C;
    localparam logic [7:0] OFS_PIN_ROUTE = 8'hA0;
    localparam logic [7:0] OFS_RAW_FLAGS = 8'hA4;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'hA8;

    // control register fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_RST_BIT = 1;

    // output mode field: 16 channels in the first word, the rest in the second
    localparam int MODE_LO_BITS = 32;
    localparam int MODE_HI_BITS = 14;

    // reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    // output mode encodings
    localparam logic [1:0] MODE_PWM1 = 2'h0;
    localparam logic [1:0] MODE_PWM2 = 2'h1;
    localparam logic [1:0] MODE_LOW  = 2'h2;
    localparam logic [1:0] MODE_HIGH = 2'h3;

    // most channels that may run as PWM at once
    localparam int PWM_MAX = 4;

endpackage : t16_pkg

/* inc/t16_cnt_if.sv */
`timescale 1ns/1ns
interface t16_cnt_if;
    logic [15:0] tc;
    logic        run;
    logic        wrap;
    logic        ce;

    modport src  (output tc, output run, output wrap, output ce);
    modport chan (input  tc, input  run, input  wrap, input  ce);
endinterface : t16_cnt_if

/* rtl/t16_chan.sv */
`timescale 1ns/1ns
module t16_chan
(
    t16_cnt_if.chan          cnt,
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [15:0] i_match_val,
    input  wire logic [1:0]  i_mode,
    input  wire logic        i_pwm_on,
    input  wire logic        i_ext_lvl,
    input  wire logic        i_route,
    input  wire logic        i_gpio_out,
    input  wire logic        i_gpio_oe,
    output logic             o_hit,
    output logic             o_pin_out,
    output logic             o_pin_oe
);
    logic wave_q;
    logic lvl;
    logic drive;

    assign o_hit = cnt.run && (cnt.tc == i_match_val);

    // the cycle wrap wins over a match in the same cycle, so a channel
    // whose match equals the cycle length keeps its wave low
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            wave_q <= 1'b0;
        else if (cnt.ce)
        begin
            if (cnt.wrap)
                wave_q <= 1'b0;
            else if (o_hit)
                wave_q <= 1'b1;
        end
    end

    always_comb
    begin
        case (i_mode)
            t16_pkg::MODE_PWM1: lvl = wave_q;
            t16_pkg::MODE_PWM2: lvl = ~wave_q;
            t16_pkg::MODE_LOW:  lvl = 1'b0;
            t16_pkg::MODE_HIGH: lvl = 1'b1;
            default:            lvl = 1'b0;
        endcase
    end

    assign drive = i_pwm_on ? lvl : i_ext_lvl;

    // pin registered: gpio path also sees one cycle of latency
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_pin_out <= 1'b0;
            o_pin_oe  <= 1'b0;
        end
        else if (cnt.ce)
        begin
            o_pin_out <= i_route ? drive : i_gpio_out;
            o_pin_oe  <= i_route ? 1'b1  : i_gpio_oe;
        end
    end

endmodule : t16_chan

/* rtl/t16_top.sv */
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
// Overview of operation
// - each match output is independently PWM or driven by its external-match bit
// - at most four channels run as PWM at once, lowest enabled channels win
// - a separate match register sets the PWM cycle length
// - a counter match on a non-cycle register drives that PWM output high in mode 1, low in mode 2
// - a match on the cycle-length register returns the counter to zero
// - a mode-1 PWM output is cleared and a mode-2 one set when the counter returns to zero
// - pin route bit clear gives the pin to gpio, set gives it the match output
// - a routed pin shows PWM if its mode bit is set and it wins a PWM slot, else the external level
// - pin route register resets to zero, bits 31 to 23 read zero
// - raw flags are kept unmasked, only enabled flags request an interrupt
// - capture channel zero event sets a read-only raw flag at bit 24
// - match channel events set read-only raw flags at their own bit positions
// - the PWM mode select register picks external level or PWM per channel
// - writing one to the clear register clears a raw flag, zero does nothing
// - a two-bit mode picks PWM mode 1, mode 2, forced low or forced high
module t16_top
#(
    parameter int N_PWM_MAX = t16_pkg::PWM_MAX
)
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire logic        i_capture_channel_zero,
    input  wire logic [22:0] i_gpio_out,
    input  wire logic [22:0] i_gpio_oe,
    output logic      [22:0] o_pin_out,
    output logic      [22:0] o_pin_oe,
    output logic             o_irq
);
    localparam int NC = t16_pkg::N_CH;
    localparam int NM = t16_pkg::N_MR;
    localparam int FW = t16_pkg::FLAG_W;

    logic [1:0]                ctrl_q;
    logic [t16_pkg::CW-1:0]    tc_q;
    logic [t16_pkg::CW-1:0]    mr_q [NM];
    logic [NC-1:0]             ext_q;
    logic [2*NC-1:0]           mode_q;
    logic [FW-1:0]             ie_q;
    logic [NC-1:0]             pwm_en_q;
    logic [NC-1:0]             route_q;
    logic [FW-1:0]             ris_q;
    logic [FW-1:0]             ris_d;
    logic [31:0]               rdata_q;
    logic                      cap_s1_q;
    logic                      cap_s2_q;
    logic                      cap_s3_q;
    logic                      cap_evt;
    logic                      run;
    logic                      cyc_hit;
    logic                      sw_clr;
    logic                      wrap;
    logic [NM-1:0]             hit;
    logic [NC-1:0]             pwm_grant;
    logic [4:0]                pwm_cnt;
    logic                      mr_sel;
    logic [4:0]                mr_idx;
    logic [FW-1:0]             clr;
    logic [31:0]               rd_mux;

    t16_cnt_if cnt_bus ();

    assign run     = ctrl_q[t16_pkg::CTRL_RUN_BIT];
    assign mr_sel  = (i_addr >= t16_pkg::OFS_MR_FIRST) && (i_addr <= t16_pkg::OFS_MR_LAST)
                     && (i_addr[1:0] == 2'h0);
    assign mr_idx  = 5'((i_addr - t16_pkg::OFS_MR_FIRST) >> 2);
    assign sw_clr  = i_wr && (i_addr == t16_pkg::OFS_CTRL) && i_wdata[t16_pkg::CTRL_RST_BIT];

    // cycle-length register is kept apart from the output channels
    assign cyc_hit = run && (tc_q == mr_q[t16_pkg::CYC_MR]);
    assign wrap    = cyc_hit || sw_clr;
    assign hit[t16_pkg::CYC_MR] = cyc_hit;

    assign cnt_bus.tc   = tc_q;
    assign cnt_bus.run  = run;
    assign cnt_bus.wrap = wrap;
    assign cnt_bus.ce   = i_ce;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            ctrl_q <= 2'h0;
        else if (i_ce && i_wr && i_addr == t16_pkg::OFS_CTRL)
            ctrl_q <= {1'b0, i_wdata[t16_pkg::CTRL_RUN_BIT]};
    end

    // counter: a software write of the count loses to a wrap in the same cycle
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            tc_q <= t16_pkg::CW'(t16_pkg::RST_ZERO);
        else if (i_ce)
        begin
            if (wrap)
                tc_q <= t16_pkg::CW'(t16_pkg::RST_ZERO);
            else if (i_wr && i_addr == t16_pkg::OFS_TC)
                tc_q <= i_wdata[t16_pkg::CW-1:0];
            else if (run)
                tc_q <= tc_q + 16'h0001;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            for (int k = 0; k < NM; k++)
                mr_q[k] <= t16_pkg::CW'(t16_pkg::RST_ZERO);
        end
        else if (i_ce && i_wr && mr_sel)
            mr_q[mr_idx] <= i_wdata[t16_pkg::CW-1:0];
    end

    // output configuration and interrupt enable registers
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ext_q    <= NC'(t16_pkg::RST_ZERO);
            mode_q   <= (2*NC)'(t16_pkg::RST_ZERO);
            pwm_en_q <= NC'(t16_pkg::RST_ZERO);
            route_q  <= NC'(t16_pkg::RST_ZERO);
            ie_q     <= FW'(t16_pkg::RST_ZERO);
        end
        else if (i_ce && i_wr)
        begin
            case (i_addr)
                t16_pkg::OFS_EXT_MATCH: ext_q <= i_wdata[NC-1:0];
                t16_pkg::OFS_OUT_MODE0:
                    mode_q[t16_pkg::MODE_LO_BITS-1:0] <= i_wdata;
                t16_pkg::OFS_OUT_MODE1:
                    mode_q[2*NC-1:t16_pkg::MODE_LO_BITS] <= i_wdata[t16_pkg::MODE_HI_BITS-1:0];
                t16_pkg::OFS_IRQ_EN:    ie_q <= i_wdata[FW-1:0];
                t16_pkg::OFS_PWM_MODE:  pwm_en_q <= i_wdata[NC-1:0];
                t16_pkg::OFS_PIN_ROUTE: route_q <= i_wdata[NC-1:0];
                default: ;
            endcase
        end
    end

    // only the lowest enabled channels up to the limit get a PWM waveform;
    // the rest fall back to their external-match level
    always_comb
    begin
        pwm_cnt = 5'h00;
        for (int k = 0; k < NC; k++)
        begin
            pwm_grant[k] = pwm_en_q[k] && (pwm_cnt < 5'(N_PWM_MAX));
            if (pwm_en_q[k])
                pwm_cnt = pwm_cnt + 5'h01;
        end
    end

    // capture input comes from a pin, so it is synchronised first
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cap_s1_q <= 1'b0;
            cap_s2_q <= 1'b0;
            cap_s3_q <= 1'b0;
        end
        else if (i_ce)
        begin
            cap_s1_q <= i_capture_channel_zero;
            cap_s2_q <= cap_s1_q;
            cap_s3_q <= cap_s2_q;
        end
    end

    assign cap_evt = cap_s2_q && !cap_s3_q;

    // raw flags: a new event beats a clear written in the same cycle
    assign clr = (i_wr && i_addr == t16_pkg::OFS_IRQ_CLEAR) ? i_wdata[FW-1:0] : FW'(t16_pkg::RST_ZERO);

    always_comb
    begin
        ris_d = ris_q & ~clr;
        ris_d[NM-1:0] = ris_d[NM-1:0] | hit;
        ris_d[t16_pkg::CAPTURE_CHANNEL_ZERO_BIT] = ris_d[t16_pkg::CAPTURE_CHANNEL_ZERO_BIT] | cap_evt;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            ris_q <= FW'(t16_pkg::RST_ZERO);
        else if (i_ce)
            ris_q <= ris_d;
    end

    assign o_irq = |(ris_q & ie_q);

    always_comb
    begin
        rd_mux = t16_pkg::RST_ZERO;
        if (mr_sel)
            rd_mux = 32'(mr_q[mr_idx]);
        else
        begin
            case (i_addr)
                t16_pkg::OFS_CTRL:      rd_mux = 32'(ctrl_q);
                t16_pkg::OFS_TC:        rd_mux = 32'(tc_q);
                t16_pkg::OFS_EXT_MATCH: rd_mux = 32'(ext_q);
                t16_pkg::OFS_OUT_MODE0: rd_mux = mode_q[t16_pkg::MODE_LO_BITS-1:0];
                t16_pkg::OFS_OUT_MODE1: rd_mux = 32'(mode_q[2*NC-1:t16_pkg::MODE_LO_BITS]);
                t16_pkg::OFS_IRQ_EN:    rd_mux = 32'(ie_q);
                t16_pkg::OFS_PWM_MODE:  rd_mux = 32'(pwm_en_q);
                t16_pkg::OFS_PIN_ROUTE: rd_mux = 32'(route_q);
                t16_pkg::OFS_RAW_FLAGS: rd_mux = 32'(ris_q);
                default:                rd_mux = t16_pkg::RST_ZERO;
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            rdata_q <= t16_pkg::RST_ZERO;
        else if (i_ce)
            rdata_q <= i_rd ? rd_mux : t16_pkg::RST_ZERO;
    end

    assign o_rdata = rdata_q;

    generate
        for (genvar g = 0; g < NC; g++)
        begin : g_ch
            t16_chan u_chan
            (
                .cnt         (cnt_bus.chan),
                .i_clk       (i_clk),
                .i_rst       (i_rst),
                .i_match_val (mr_q[g]),
                .i_mode      (mode_q[2*g+1:2*g]),
                .i_pwm_on    (pwm_grant[g]),
                .i_ext_lvl   (ext_q[g]),
                .i_route     (route_q[g]),
                .i_gpio_out  (i_gpio_out[g]),
                .i_gpio_oe   (i_gpio_oe[g]),
                .o_hit       (hit[g]),
                .o_pin_out   (o_pin_out[g]),
                .o_pin_oe    (o_pin_oe[g])
            );
        end
    endgenerate

endmodule : t16_top

/* verif/t16_monitor.sv */
`timescale 1ns/1ns
module t16_mon
(
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_ce,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [22:0] i_gpio_out,
    input wire logic [22:0] i_gpio_oe,
    input wire logic [22:0] o_pin_out,
    input wire logic [22:0] o_pin_oe,
    input wire logic        o_irq
);
    // shadows of the software levels that steer the pins and the irq
    logic [22:0] rt_q;
    logic [22:0] sel_q;
    logic [22:0] ext_q;
    logic [24:0] en_q;
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rt_q  <= '0;
            sel_q <= '0;
            ext_q <= '0;
            en_q  <= '0;
        end
        else if (i_wr && i_ce)
        begin
            if (i_addr == 8'hA0) rt_q <= i_wdata[22:0];
            if (i_addr == 8'h9C) sel_q <= i_wdata[22:0];
            if (i_addr == 8'h80) ext_q <= i_wdata[22:0];
            if (i_addr == 8'h94) en_q <= i_wdata[24:0];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_rd(logic [7:0] a); i_rd && i_addr == a; endsequence
    // the first edge after reset still sees reset-time inputs through past,
    // and a frozen cycle leaves the pins as they were, so skip both
    sequence s_run; !$past(i_rst) && $past(i_ce); endsequence
    property p_route_rd; s_rd(8'hA0) |=> o_rdata == {9'h0, $past(rt_q)}; endproperty
    a_route_rd: assert property (p_route_rd) else $error("route readback wrong");
    property p_sel_rd; s_rd(8'h9C) |=> o_rdata == {9'h0, $past(sel_q)}; endproperty
    a_sel_rd: assert property (p_sel_rd) else $error("mode select readback wrong");
    property p_flag_rsv; s_rd(8'hA4) |=> o_rdata[31:25] == 7'h0; endproperty
    a_flag_rsv: assert property (p_flag_rsv) else $error("flag upper bits set");
    property p_clr_rd; s_rd(8'hA8) |=> o_rdata == 32'h0; endproperty
    a_clr_rd: assert property (p_clr_rd) else $error("clear register readable");
    property p_pin_oe; s_run |-> o_pin_oe == ($past(rt_q) | ($past(i_gpio_oe) & ~$past(rt_q))); endproperty
    a_pin_oe: assert property (p_pin_oe) else $error("pin enable wrong");
    property p_pin_io;
        s_run |-> ((o_pin_out ^ $past(i_gpio_out)) & $past(i_gpio_oe) & ~$past(rt_q)) == 23'h0;
    endproperty
    a_pin_io: assert property (p_pin_io) else $error("gpio level not passed");
    property p_pin_ext; s_run |-> ((o_pin_out ^ $past(ext_q)) & $past(rt_q) & ~$past(sel_q)) == 23'h0; endproperty
    a_pin_ext: assert property (p_pin_ext) else $error("external level not shown");
    property p_irq_mask; en_q == 25'h0 |-> !o_irq; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while all masked");
endmodule : t16_mon

/* verif/t16_pins.sv */
`timescale 1ns/1ns
module t16_pins
(
    input  wire logic        i_clk,
    input  wire logic        i_cap_req,
    output logic      [22:0] o_gpio_out,
    output logic      [22:0] o_gpio_oe,
    output logic             o_cap
);
    // gpio side changes every cycle so a stale pass-through cannot hide
    logic [31:0] s_q = 32'h0000_454C;
    logic        c_q = 1'b0;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    always_ff @(posedge i_clk)
    begin
        s_q <= xs(s_q);
        c_q <= i_cap_req;
    end
    assign o_gpio_out = s_q[22:0];
    assign o_gpio_oe  = s_q[31:9];
    assign o_cap      = c_q;
endmodule : t16_pins

/* verif/t16_top_tb.sv */
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) \
    begin errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module t16_top_tb;
    logic        i_clk   = 1'b0;
    logic        i_rst   = 1'b1;
    logic [7:0]  i_addr  = 8'h0;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr    = 1'b0;
    logic        i_rd    = 1'b0;
    logic        cap_req = 1'b0;
    logic        ce      = 1'b1;
    logic [31:0] o_rdata;
    logic        i_capture_channel_zero;
    logic [22:0] i_gpio_out;
    logic [22:0] i_gpio_oe;
    logic [22:0] o_pin_out;
    logic [22:0] o_pin_oe;
    logic        o_irq;
    logic [31:0] seed = 32'h0000_454C;
    logic [31:0] d;
    logic [31:0] v;
    int          errors = 0;
    int          checks_done = 0;
    int          hi0;
    int          hi4;
    int          m;
    always #20 i_clk = ~i_clk;
    t16_top DUT (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_capture_channel_zero(i_capture_channel_zero), .i_gpio_out(i_gpio_out),
        .i_gpio_oe(i_gpio_oe), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_irq(o_irq));
    t16_pins PTR (.i_clk(i_clk), .i_cap_req(cap_req), .o_gpio_out(i_gpio_out),
        .o_gpio_oe(i_gpio_oe), .o_cap(i_capture_channel_zero));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    // high cycles over four periods of ten, the wave rises one edge after the match
    function automatic int exp_hi(input int md, input int mv);
        case (md)
            0: return 4 * (9 - mv);
            1: return 4 * (mv + 1);
            2: return 0;
            default: return 40;
        endcase
    endfunction : exp_hi
    // the gap cycle keeps two strobes from landing in one time step
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= w;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(posedge i_clk);
        d = o_rdata;
    endtask : rd
    task automatic finish_test;
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (5000) @(posedge i_clk);
        errors++;
        finish_test();
    end
    initial
    begin
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        rd(8'hA0);
        `CHK("route reset", 32'h0, d)
        // a frozen cycle must swallow a write
        ce <= 1'b0;
        wr(8'hA0, 32'h0000_0007);
        ce <= 1'b1;
        rd(8'hA0);
        `CHK("write while frozen", 32'h0, d)
        wr(8'hA4, 32'hFFFF_FFFF);
        rd(8'hA4);
        `CHK("flags read only", 32'h0, d)
        rd(8'hA8);
        `CHK("clear reg read", 32'h0, d)
        for (int i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            v = (i == 0) ? 32'hFFFF_FFFF : seed;
            wr(8'hA0, v);
            wr(8'h9C, v);
            wr(8'h80, ~v);
            rd(8'hA0);
            `CHK("route", {9'h0, v[22:0]}, d)
            rd(8'h9C);
            `CHK("mode select", {9'h0, v[22:0]}, d)
        end
        cap_req <= 1'b1;
        repeat (2) @(posedge i_clk);
        cap_req <= 1'b0;
        repeat (6) @(posedge i_clk);
        rd(8'hA4);
        `CHK("capture flag", 32'h0100_0000, d)
        wr(8'h94, 32'h0100_0000);
        `CHK("irq enabled", 1'b1, o_irq)
        wr(8'h94, 32'h00FF_FFFF);
        `CHK("irq masked", 1'b0, o_irq)
        wr(8'hA8, 32'h0);
        rd(8'hA4);
        `CHK("clear zero", 32'h0100_0000, d)
        wr(8'hA8, 32'h0100_0000);
        rd(8'hA4);
        `CHK("clear one", 32'h0, d)
        wr(8'h94, 32'h0);
        wr(8'h7C, 32'h9);
        wr(8'hA0, 32'h1F);
        wr(8'h9C, 32'h1F);
        wr(8'h80, 32'h10);
        for (int md = 0; md < 4; md++)
        begin
            seed = xs(seed);
            m = 1 + int'(seed[2:0]);
            wr(8'h00, 32'h2);
            wr(8'h20, 32'(m));
            wr(8'h84, 32'(md));
            wr(8'h00, 32'h1);
            repeat (12) @(posedge i_clk);
            hi0 = 0;
            hi4 = 0;
            repeat (40)
            begin
                @(posedge i_clk);
                hi0 += (o_pin_out[0] === 1'b1);
                hi4 += (o_pin_out[4] === 1'b1);
            end
            `CHK("duty", exp_hi(md, m), hi0)
            `CHK("fifth pwm channel", 40, hi4)
        end
        wr(8'h00, 32'h0);
        rd(8'hA4);
        `CHK("match flags", 24'hFF_FFFF, d[23:0])
        wr(8'h94, 32'h1);
        `CHK("match irq", 1'b1, o_irq)
        wr(8'hA8, 32'h01FF_FFFF);
        rd(8'hA4);
        `CHK("all cleared", 32'h0, d)
        finish_test();
    end
endmodule : t16_top_tb
bind t16_top t16_mon u_mon (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_gpio_out(i_gpio_out),
    .i_gpio_oe(i_gpio_oe), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_irq(o_irq));
